// ==== rtc_core.sv ====
/*
 * Clock/calendar core: serial slave, BCD time chain, snapshot buffer, reset pin
 * supervisor, temperature schedule, wave pin, and the write FIFO feeding registers.
 * Assumes SCLK is far slower than CLK (at least 4 CLK cycles per half period).
 */
`timescale 1ns/100ps
module rtc_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    // Depth must be a power of two: pointers wrap naturally
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } rtc_fifo_st_t;
    rtc_fifo_st_t q, d;
    logic [AW:0] fill;

    always_comb begin
        d = q;
        fill = q.wp - q.rp;
        in_ready = fill != (AW+1)'(D);
        out_valid = q.wp != q.rp;
        out_data = q.mem[q.rp[AW-1:0]];
        if (in_valid && in_ready) begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            d.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : rtc_fifo

module rtc_core import rtc_pkg::*; #(
    parameter int OSC_DIV = OSC_DIV_DEF,
    parameter int REC_HOLD_CYC = REC_HOLD_CYC_DEF,
    parameter int PB_DB_CYC = PB_DB_CYC_DEF,
    parameter int PB_HOLD_CYC = PB_HOLD_CYC_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_OE,
    input wire logic RST_N_I,
    output logic RST_N_O,
    output logic RST_N_OE,
    input wire logic VCC_ABOVE_PF,
    input wire logic VCC_ABOVE_BAT,
    input wire logic ALARM_MATCH,
    output logic ALARM_OR_WAVE_O,
    output logic ALARM_OR_WAVE_OE,
    output logic TEMP_SAMPLE,
    output logic CLOCK_ACCESS_OK,
    output logic OSC_RUNNING,
    output logic WR_FIFO_READY
);
    typedef struct packed {
        logic cs_m, cs_s, cs_p, sclk_m, sclk_s, sclk_p, din_m, din_s;
        logic pf_m, pf_s, pf_p, bat_m, bat_s, rst_m, rst_s, rst_p, drv_m, drv_s;
        logic cpol, first, wr, dout, dout_oe;
        logic [2:0] bits;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [6:0] ptr;
        logic [NREG-1:0][7:0] regs;
        logic [6:0][7:0] snap;
        logic [255:0][7:0] sram;
        logic [15:0] div;
        logic [14:0] sub;
        logic armed, oscr, acc, tsample, rdrive, wave_oe;
        logic [9:0] tsec;
        rtc_rst_st_t rs;
        logic [31:0] rcnt;
    } rtc_st_t;
    rtc_st_t q, d;

    logic tick32, sec_tick, below_both, pf_rst, clk_ok, sram_ok, osc_run;
    logic lead, trail, cs_fall, ptr_ok, byte_done, c, wv, wr_sec;
    logic push_valid, push_ready, pop_valid, pop_ready;
    logic [FIFO_W-1:0] push_data, pop_data;
    logic [8:0] st;
    logic [7:0] h, rdata;
    logic [9:0] period;
    logic [6:0] nxt;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // Returns {wrapped, next value}
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        bcd_step = (v == last) ? {1'b1, first} : {1'b0, bcd_inc(v)};
    endfunction : bcd_step

    function automatic logic [7:0] month_last(input logic [4:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            5'h02: month_last = leap ? DAYS_29 : DAYS_28;
            5'h04, 5'h06, 5'h09, 5'h11: month_last = DAYS_30;
            default: month_last = DAYS_31;
        endcase
    endfunction : month_last

    rtc_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_wr_fifo (
        .clk(CLK),
        .rst(SYS_RST),
        .in_valid(push_valid),
        .in_data(push_data),
        .in_ready(push_ready),
        .out_valid(pop_valid),
        .out_data(pop_data),
        .out_ready(pop_ready)
    );

    always_comb begin
        d = q;
        d.cs_m = CS_N;
        d.cs_s = q.cs_m;
        d.cs_p = q.cs_s;
        d.sclk_m = SCLK;
        d.sclk_s = q.sclk_m;
        d.sclk_p = q.sclk_s;
        d.din_m = DIN;
        d.din_s = q.din_m;
        d.pf_m = VCC_ABOVE_PF;
        d.pf_s = q.pf_m;
        d.pf_p = q.pf_s;
        d.bat_m = VCC_ABOVE_BAT;
        d.bat_s = q.bat_m;
        d.rst_m = RST_N_I;
        d.rst_s = q.rst_m;
        d.rst_p = q.rst_s;
        // Own drive delayed like the line sync, so its echo is not a button edge
        d.drv_m = q.rdrive;
        d.drv_s = q.drv_m;

        below_both = !q.pf_s && !q.bat_s;
        pf_rst = (q.rs == ST_PF) || (q.rs == ST_REC);
        clk_ok = !below_both && !pf_rst;
        sram_ok = !below_both;
        osc_run = q.armed && !(below_both && q.regs[REG_CTRL][CTRL_OSC_STOP]);
        if (q.pf_s) begin
            d.armed = 1'b1;
        end
        d.oscr = osc_run;
        d.acc = clk_ok;

        // Sub-second chain, frozen while the oscillator is stopped
        tick32 = osc_run && (q.div == 16'(OSC_DIV - 1));
        sec_tick = tick32 && (q.sub == '1);
        if (osc_run) begin
            d.div = tick32 ? '0 : q.div + 16'h0001;
        end
        if (tick32) begin
            d.sub = q.sub + 15'h0001;
        end

        c = 1'b0;
        st = '0;
        h = q.regs[REG_HOUR];
        if (sec_tick) begin
            st = bcd_step(q.regs[REG_SEC], SEC_LAST, BCD_ZERO);
            d.regs[REG_SEC] = st[7:0];
            c = st[8];
            if (c) begin
                st = bcd_step(q.regs[REG_MIN], SEC_LAST, BCD_ZERO);
                d.regs[REG_MIN] = st[7:0];
                c = st[8];
            end
            if (c) begin
                if (h[HR_MODE12]) begin
                    st = bcd_step({3'b000, h[4:0]}, {3'b000, HR12_TWELVE}, BCD_ONE);
                    c = 1'b0;
                    if (h[4:0] == HR12_ELEVEN) begin
                        h[HR_PM] = !h[HR_PM];
                        c = !h[HR_PM];
                    end
                    h[4:0] = st[4:0];
                    if (st[8]) begin
                        h[4:0] = HR12_ONE;
                    end
                end else begin
                    st = bcd_step({2'b00, h[5:0]}, HR24_LAST, BCD_ZERO);
                    h = st[7:0];
                    c = st[8];
                end
                d.regs[REG_HOUR] = h;
            end
            if (c) begin
                st = bcd_step(q.regs[REG_DAY], DAY_LAST, BCD_ONE);
                d.regs[REG_DAY] = st[7:0];
                st = bcd_step(q.regs[REG_DATE],
                              month_last(q.regs[REG_MONTH][4:0], q.regs[REG_YEAR]), BCD_ONE);
                d.regs[REG_DATE] = st[7:0];
                c = st[8];
            end
            if (c) begin
                st = bcd_step({3'b000, q.regs[REG_MONTH][4:0]}, MON_LAST, BCD_ONE);
                d.regs[REG_MONTH][4:0] = st[4:0];
                c = st[8];
            end
            if (c) begin
                st = bcd_step(q.regs[REG_YEAR], YEAR_LAST, BCD_ZERO);
                d.regs[REG_YEAR] = st[7:0];
                if (st[8]) begin
                    d.regs[REG_MONTH][MON_CENT] = !q.regs[REG_MONTH][MON_CENT];
                end
            end
        end

        // Temperature schedule
        d.tsample = 1'b0;
        period = 10'(TEMP_PERIOD_S) << {q.regs[REG_STAT][STAT_CONV_HI],
                                        q.regs[REG_STAT][STAT_CONV_LO]};
        if (q.pf_s && !q.pf_p) begin
            d.tsample = 1'b1;
            d.tsec = '0;
        end else if (sec_tick) begin
            d.tsec = q.tsec + 10'h001;
            if (q.tsec == period - 10'h001) begin
                d.tsample = 1'b1;
                d.tsec = '0;
            end
        end

        // Reset pin supervisor
        unique case (q.rs)
            ST_IDLE: begin
                if (q.rst_p && !q.rst_s && !q.drv_s) begin
                    d.rs = ST_DB;
                    d.rcnt = '0;
                end
            end
            ST_PF: begin
                if (q.pf_s) begin
                    d.rcnt = '0;
                    // First power-up or a set CTRL_OSC_STOP bit skips the hold
                    d.rs = (q.regs[REG_CTRL][CTRL_OSC_STOP] || !q.armed) ? ST_IDLE
                                                                        : ST_REC;
                end
            end
            ST_REC: begin
                d.rcnt = q.rcnt + 32'h0000_0001;
                if (q.rcnt == 32'(REC_HOLD_CYC - 1)) begin
                    d.rs = ST_IDLE;
                end
            end
            ST_DB: begin
                d.rcnt = q.rcnt + 32'h0000_0001;
                if (q.rcnt == 32'(PB_DB_CYC - 1)) begin
                    d.rs = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (q.rst_s) begin
                    d.rs = ST_HOLD;
                    d.rcnt = '0;
                end
            end
            ST_HOLD: begin
                d.rcnt = q.rcnt + 32'h0000_0001;
                if (q.rcnt == 32'(PB_HOLD_CYC - 1)) begin
                    d.rs = ST_IDLE;
                end
            end
            default: d.rs = ST_IDLE;
        endcase
        if (!q.pf_s) begin
            d.rs = ST_PF;
        end
        d.rdrive = (d.rs != ST_IDLE) && (d.rs != ST_WAIT);

        // Serial slave, mode picked at select fall
        cs_fall = q.cs_p && !q.cs_s;
        lead = !q.cs_s && !cs_fall && (q.sclk_s != q.sclk_p) && (q.sclk_p == q.cpol);
        trail = !q.cs_s && !cs_fall && (q.sclk_s != q.sclk_p) && (q.sclk_s == q.cpol);
        ptr_ok = ((q.ptr <= REG_LAST) && clk_ok)
              || ((q.ptr == REG_SRAM_ADDR || q.ptr == REG_SRAM_DATA) && sram_ok);
        rdata = (q.ptr <= REG_YEAR) ? q.snap[q.ptr[2:0]]
              : (q.ptr == REG_SRAM_DATA) ? q.sram[q.regs[REG_SRAM_ADDR]] : q.regs[q.ptr];
        nxt = (q.ptr == REG_LAST) ? REG_FIRST
            : (q.ptr == REG_SRAM_DATA) ? q.ptr : q.ptr + 7'h01;
        byte_done = trail && (q.bits == 3'h7);
        push_data = {q.ptr, q.rx[6:0], q.din_s};
        push_valid = byte_done && !q.first && q.wr && ptr_ok;
        if (q.cs_s) begin
            d.dout_oe = 1'b0;
        end
        if (cs_fall) begin
            d.cpol = q.sclk_s;
            d.first = 1'b1;
            d.bits = '0;
            d.snap = q.regs[6:0];
        end
        if (lead) begin
            if (q.bits == 3'h0) begin
                d.dout_oe = !q.first && !q.wr && ptr_ok;
                d.dout = rdata[7];
                d.tx = {rdata[6:0], 1'b0};
            end else begin
                d.dout = q.tx[7];
                d.tx = {q.tx[6:0], 1'b0};
            end
        end
        if (trail) begin
            d.rx = {q.rx[6:0], q.din_s};
            d.bits = q.bits + 3'h1;
        end
        if (byte_done) begin
            if (q.first) begin
                d.first = 1'b0;
                d.wr = q.rx[WR_BIT - 1];
                d.ptr = {q.rx[5:0], q.din_s};
            end else if (ptr_ok) begin
                d.ptr = nxt;
                if (!q.wr && q.ptr == REG_SRAM_DATA) begin
                    d.regs[REG_SRAM_ADDR] = q.regs[REG_SRAM_ADDR] + 8'h01;
                end
                if (!q.wr && nxt == REG_FIRST) begin
                    d.snap = q.regs[6:0];
                end
            end
        end

        // Drain stalls on the second tick so a write never races the time chain
        pop_ready = !sec_tick;
        wr_sec = pop_valid && pop_ready && (pop_data[FIFO_W-1 -: PTR_W] == REG_SEC);
        if (pop_valid && pop_ready) begin
            if (pop_data[FIFO_W-1 -: PTR_W] == REG_SRAM_DATA) begin
                d.sram[q.regs[REG_SRAM_ADDR]] = pop_data[7:0];
                d.regs[REG_SRAM_ADDR] = q.regs[REG_SRAM_ADDR] + 8'h01;
            end else if (pop_data[FIFO_W-1 -: PTR_W] != REG_TEMP_MSB
                      && pop_data[FIFO_W-1 -: PTR_W] != REG_TEMP_LSB) begin
                d.regs[pop_data[FIFO_W-1 -: PTR_W]] = pop_data[7:0];
            end
            if (wr_sec) begin
                d.sub = '0;
                d.div = '0;
            end
        end
        if (!osc_run) begin
            d.regs[REG_STAT][STAT_OSF] = 1'b1;
        end

        unique case ({q.regs[REG_CTRL][CTRL_RATE_HI], q.regs[REG_CTRL][CTRL_RATE_LO]})
            2'b00: wv = q.sub[WAVE_1HZ];
            2'b01: wv = q.sub[WAVE_1K];
            2'b10: wv = q.sub[WAVE_4K];
            2'b11: wv = q.sub[WAVE_8K];
        endcase
        d.wave_oe = q.regs[REG_CTRL][CTRL_SEL] ? ALARM_MATCH : !wv;
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q <= '0;
            q.cs_m <= 1'b1;
            q.cs_s <= 1'b1;
            q.cs_p <= 1'b1;
            q.rst_m <= 1'b1;
            q.rst_s <= 1'b1;
            q.rst_p <= 1'b1;
            q.regs[REG_CTRL] <= CTRL_RST;
            q.rs <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign DOUT = q.dout;
    assign DOUT_OE = q.dout_oe;
    assign RST_N_O = 1'b0;
    assign RST_N_OE = q.rdrive;
    assign ALARM_OR_WAVE_O = 1'b0;
    assign ALARM_OR_WAVE_OE = q.wave_oe;
    assign TEMP_SAMPLE = q.tsample;
    assign CLOCK_ACCESS_OK = q.acc;
    assign OSC_RUNNING = q.oscr;
    assign WR_FIFO_READY = push_ready;

    a_pf_drive_line: assert property (@(posedge CLK) disable iff (SYS_RST)
        !q.pf_s |=> RST_N_OE && q.rs == ST_PF)
        else $error("power fail did not drive reset line");
    a_access_blocked: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!q.pf_s && !q.bat_s) |=> !CLOCK_ACCESS_OK)
        else $error("access open with both supplies low");
    a_access_after_release: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(CLOCK_ACCESS_OK) |-> !RST_N_OE && !$past(q.rs == ST_REC) && !$past(q.rs == ST_PF))
        else $error("access returned before reset release");
    a_rec_skip: assert property (@(posedge CLK) disable iff (SYS_RST)
        (q.rs == ST_PF && q.pf_s && q.regs[REG_CTRL][CTRL_OSC_STOP]) |=> q.rs == ST_IDLE)
        else $error("recovery hold not skipped");
    a_osc_unarmed: assert property (@(posedge CLK) disable iff (SYS_RST)
        !q.armed |=> $stable(q.sub) && !OSC_RUNNING)
        else $error("oscillator ran before first supply");
    a_osc_batt_stop: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!q.pf_s && !q.bat_s && q.regs[REG_CTRL][CTRL_OSC_STOP] && !wr_sec)
            |=> $stable(q.sub))
        else $error("oscillator ran on battery with stop set");
    a_debounce_drive: assert property (@(posedge CLK) disable iff (SYS_RST)
        (q.rs == ST_IDLE && q.pf_s && q.rst_p && !q.rst_s && !q.drv_s)
            |=> q.rs == ST_DB ##1 RST_N_OE)
        else $error("debounce not started on falling edge");
    a_ptr_wrap: assert property (@(posedge CLK) disable iff (SYS_RST)
        (byte_done && !q.first && ptr_ok && q.ptr == REG_LAST) |=> q.ptr == REG_FIRST)
        else $error("pointer failed to wrap");
    a_reserved_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        (byte_done && !q.first && !ptr_ok) |=> $stable(q.ptr) && !$rose(DOUT_OE))
        else $error("reserved access moved pointer");
    a_sec_write_reset: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_sec |=> q.sub == '0 && q.div == '0)
        else $error("seconds write did not reset chain");
endmodule : rtc_core

// ==== rtc_pkg.sv ====
/*
 * Shared constants, register layout and state codes of the clock/calendar core.
 * Assumes a single 25 MHz system clock; all pins but ALARM_MATCH are synchronised inside the core.
 */
package rtc_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int OSC_HZ = 32_768;
    localparam int OSC_DIV_DEF = CLK_HZ / OSC_HZ;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int REC_HOLD_MS = 100;
    localparam int PB_DEBOUNCE_MS = 100;
    localparam int PB_HOLD_MS = 100;
    localparam int REC_HOLD_CYC_DEF = REC_HOLD_MS * MS_CYC;
    localparam int PB_DB_CYC_DEF = PB_DEBOUNCE_MS * MS_CYC;
    localparam int PB_HOLD_CYC_DEF = PB_HOLD_MS * MS_CYC;
    localparam int TEMP_PERIOD_S = 64;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int PTR_W = 7;
    localparam int FIFO_W = PTR_W + 8;
    localparam int NREG = 26;
    localparam logic [6:0] REG_SEC = 7'h00;
    localparam logic [6:0] REG_MIN = 7'h01;
    localparam logic [6:0] REG_HOUR = 7'h02;
    localparam logic [6:0] REG_DAY = 7'h03;
    localparam logic [6:0] REG_DATE = 7'h04;
    localparam logic [6:0] REG_MONTH = 7'h05;
    localparam logic [6:0] REG_YEAR = 7'h06;
    localparam logic [6:0] REG_CTRL = 7'h0E;
    localparam logic [6:0] REG_STAT = 7'h0F;
    localparam logic [6:0] REG_TEMP_MSB = 7'h11;
    localparam logic [6:0] REG_TEMP_LSB = 7'h12;
    localparam logic [6:0] REG_LAST = 7'h13;
    localparam logic [6:0] REG_FIRST = 7'h00;
    localparam logic [6:0] REG_SRAM_ADDR = 7'h18;
    localparam logic [6:0] REG_SRAM_DATA = 7'h19;
    localparam int WR_BIT = 7;
    localparam int CTRL_OSC_STOP = 7;
    localparam int CTRL_RATE_HI = 4;
    localparam int CTRL_RATE_LO = 3;
    localparam int CTRL_SEL = 2;
    localparam int STAT_OSF = 7;
    localparam int STAT_CONV_HI = 5;
    localparam int STAT_CONV_LO = 4;
    localparam int HR_MODE12 = 6;
    localparam int HR_PM = 5;
    localparam int MON_CENT = 7;
    localparam int WAVE_1HZ = 14;
    localparam int WAVE_1K = 4;
    localparam int WAVE_4K = 2;
    localparam int WAVE_8K = 1;
    localparam logic [7:0] CTRL_RST = 8'h04;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] HR24_LAST = 8'h23;
    localparam logic [4:0] HR12_ELEVEN = 5'h11;
    localparam logic [4:0] HR12_TWELVE = 5'h12;
    localparam logic [4:0] HR12_ONE = 5'h01;
    localparam logic [7:0] DAY_LAST = 8'h07;
    localparam logic [7:0] MON_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PF = 3'h1,
        ST_REC = 3'h2,
        ST_DB = 3'h3,
        ST_WAIT = 3'h4,
        ST_HOLD = 3'h5
    } rtc_rst_st_t;
endpackage : rtc_pkg

// ==== rtc_spi_host.sv ====
/* SPI host model for the clock core bench, mode 3 (clock idles high).
   Assumes clk is the core clock; one SCLK half period is 4 clk. */
`timescale 1ns/100ps
module rtc_spi_host (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    logic din_q;
    logic oe_seen;
    logic [7:0] buf_q [8];
    // Idle data line is not held, so a stale bit never passes for data
    assign din = cs_n ? ~din_q : din_q;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din_q = 1'b0;
        oe_seen = 1'b0;
    end
    task automatic xfer(inout logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            sclk <= 1'b0;
            din_q <= b[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            // Sample late in the high phase, core output lags the edge
            repeat (3) @(posedge clk);
            b[i] = dout;
            oe_seen |= dout_oe;
        end
    endtask : xfer
    task automatic frame(input logic [7:0] adr, input int n);
        logic [7:0] a;
        a = adr;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (6) @(posedge clk);
        xfer(a);
        oe_seen = 1'b0;
        for (int i = 0; i < n; i++) xfer(buf_q[i]);
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : frame
endmodule : rtc_spi_host

// ==== tb.sv ====
/* Self-checking bench of the clock core: time set, rollover, pointer wrap,
   refusals, power fail and pushbutton. Assumes short counts given below. */
`timescale 1ns/100ps
module tb;
    logic clk, sys_rst, powerfail_threshold, vbat, alarm, button;
    logic cs_n, sclk, din, dout, dout_oe, rst_oe, aw_oe, temp_s, acc_ok, osc_run;
    logic [7:0] tm [8];
    int error_cnt = 0;
    int compares = 0;
    int temps = 0;
    wire logic rst_line = ~(rst_oe | button);
    rtc_core #(.OSC_DIV(2), .REC_HOLD_CYC(20), .PB_DB_CYC(20), .PB_HOLD_CYC(20)) rtc_core_i (
        .CLK(clk), .SYS_RST(sys_rst), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
        .DOUT(dout), .DOUT_OE(dout_oe), .RST_N_I(rst_line), .RST_N_O(),
        .RST_N_OE(rst_oe), .VCC_ABOVE_PF(powerfail_threshold), .VCC_ABOVE_BAT(vbat),
        .ALARM_MATCH(alarm), .ALARM_OR_WAVE_O(), .ALARM_OR_WAVE_OE(aw_oe),
        .TEMP_SAMPLE(temp_s), .CLOCK_ACCESS_OK(acc_ok), .OSC_RUNNING(osc_run),
        .WR_FIFO_READY()
    );
    rtc_spi_host rtc_spi_host_i (
        .clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (temp_s === 1'b1) temps++;
    initial begin
        #4_800_000;
        error_cnt++;
        conclude();
    end
    initial begin
        sys_rst = 1'b1;
        powerfail_threshold = 1'b1;
        vbat = 1'b1;
        alarm = 1'b0;
        button = 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge clk);
        check(rst_oe, 0);
        check(osc_run, 1);
        check(acc_ok, 1);
        alarm <= 1'b1;
        repeat (4) @(posedge clk);
        check(aw_oe, 1);
        alarm <= 1'b0;
        repeat (4) @(posedge clk);
        check(aw_oe, 0);
        // Wave mode at 1 Hz, so the seconds write below sets its phase
        rtc_spi_host_i.buf_q[0] = 8'h00;
        rtc_spi_host_i.frame(8'h8E, 1);
        // 23:59:59, day 7, 31 Dec 99, 24 hour mode
        tm = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h00};
        rtc_spi_host_i.buf_q = tm;
        rtc_spi_host_i.frame(8'h80, 7);
        rtc_spi_host_i.frame(8'h00, 7);
        for (int i = 0; i < 7; i++) check(rtc_spi_host_i.buf_q[i], tm[i]);
        check(rtc_spi_host_i.oe_seen, 1);
        rtc_spi_host_i.frame(8'h13, 2);
        check(rtc_spi_host_i.buf_q[1], 8'h59);
        rtc_spi_host_i.frame(8'h14, 1);
        check(rtc_spi_host_i.oe_seen, 0);
        // One second is 65536 clocks with the short divider
        // About 1300 clocks have passed since the seconds write; wave rises at 32768
        repeat (31000) @(posedge clk);
        check(aw_oe, 1);
        repeat (1000) @(posedge clk);
        check(aw_oe, 0);
        repeat (33536) @(posedge clk);
        tm = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00, 8'h00};
        rtc_spi_host_i.frame(8'h00, 7);
        for (int i = 0; i < 3; i++) check(rtc_spi_host_i.buf_q[i], tm[i]);
        check(rtc_spi_host_i.buf_q[3], tm[3]);
        for (int i = 4; i < 7; i++) check(rtc_spi_host_i.buf_q[i], tm[i]);
        powerfail_threshold <= 1'b0;
        vbat <= 1'b0;
        repeat (8) @(posedge clk);
        check(rst_oe, 1);
        check(acc_ok, 0);
        rtc_spi_host_i.frame(8'h00, 1);
        check(rtc_spi_host_i.oe_seen, 0);
        temps = 0;
        powerfail_threshold <= 1'b1;
        vbat <= 1'b1;
        repeat (10) @(posedge clk);
        check(rst_oe, 1);
        repeat (25) @(posedge clk);
        check(rst_oe, 0);
        check(acc_ok, 1);
        check(8'(temps), 1);
        button <= 1'b1;
        repeat (8) @(posedge clk);
        check(rst_oe, 1);
        repeat (30) @(posedge clk);
        button <= 1'b0;
        repeat (8) @(posedge clk);
        check(rst_oe, 1);
        check(acc_ok, 1);
        repeat (30) @(posedge clk);
        check(rst_oe, 0);
        // Stop bit set: oscillator halts on battery, recovery hold skipped
        rtc_spi_host_i.buf_q[0] = 8'h80;
        rtc_spi_host_i.frame(8'h8E, 1);
        powerfail_threshold <= 1'b0;
        vbat <= 1'b0;
        repeat (8) @(posedge clk);
        check(osc_run, 0);
        powerfail_threshold <= 1'b1;
        vbat <= 1'b1;
        repeat (8) @(posedge clk);
        check(rst_oe, 0);
        check(osc_run, 1);
        conclude();
    end
endmodule : tb
